// file: sgl_pkg.sv
// Summary of operation
// - Each serial clock rise while load enable is low shifts one data bit in, most significant bit first.
// - While load enable is low the latched gain code stays unchanged.
// - Load enable rising copies the shift register into the latch.
// - While load enable is high serial clock edges do not shift.
// - Gain code is unsigned 0 to 255, all ones is maximum gain.
// - Gain rises 0.077 V/V per step above 0.316 V/V at code zero.
// - Each latched bit enables one binary-weighted attenuator stage.
// - Sleep input high selects forward mode with output stage on.
// - Sleep input low turns off output and input stages, enables hold amp.
// - Sleep mode leaves the latched gain code untouched.
// - Load enable falling freezes the latch and enables shifting.
// - Sleep input acts at any time, output off 14 clock cycles (70 ns) later.
package sgl_pkg;

  // Datapath width
  localparam int unsigned CODE_W = 8;

  // Gain law in milli V/V
  localparam int unsigned GAIN_STEP_MILLI   = 77;
  localparam int unsigned GAIN_OFFSET_MILLI = 316;
  localparam int unsigned GAIN_W            = 15;

  // Clock and sleep timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned SLEEP_OFF_NS = 45;
  // Longest time, rounded down, never below one cycle
  localparam int unsigned SLEEP_CYC_RAW = (SLEEP_OFF_NS * CLK_MHZ) / 1000;
  localparam int unsigned SLEEP_CYC     = (SLEEP_CYC_RAW < 1) ? 1 : SLEEP_CYC_RAW;
  localparam int unsigned SLEEP_CNT_W   = 5;

  // Synchroniser depth and pin reset levels
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [3:0]  PIN_IDLE    = 4'h7;

  // Pins from the external controller
  typedef struct packed {
    logic sclk;
    logic serial_gain_in;
    logic load_enable_n;
    logic amp_sleep_n;
  } sgl_pins_s;

  // Amplifier stage controls
  typedef struct packed {
    logic fwd_stage_en;
    logic in_stage_en;
    logic rev_hold_en;
  } sgl_amp_s;

  localparam logic [2:0] AMP_FWD = 3'h6;
  localparam logic [2:0] AMP_REV = 3'h1;

endpackage : sgl_pkg

// file: sgl_loader.sv
`timescale 1ns/1ps
`default_nettype none
module sgl_loader
  import sgl_pkg::*;
#(
  parameter int unsigned WIDTH = CODE_W
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire sgl_pins_s         i_pins,
  output var  logic [WIDTH-1:0]  o_atten_sel,
  output var  logic [GAIN_W-1:0] o_gain_milli,
  output var  logic              o_code_valid,
  output var  sgl_amp_s          o_amp
);

  // Pin count taken from the pin carrier
  localparam int unsigned PIN_W = $bits(sgl_pins_s);

  // Load phase as seen through the filtered load enable
  typedef enum logic [0:0] {
    SGL_LD_HOLD  = 1'b0,
    SGL_LD_SHIFT = 1'b1
  } sgl_ld_e;

  // Synchroniser stages and filtered pins
  logic [PIN_W-1:0]       pins_raw;
  logic [PIN_W-1:0]       sync1;
  logic [PIN_W-1:0]       sync2;
  logic [PIN_W-1:0]       sync3;
  sgl_pins_s              filt;
  sgl_pins_s              filt_d;

  // Edge strobes, one cycle each
  logic                   sclk_rise;
  logic                   load_rise;
  logic                   load_fall;
  logic                   sleep_edge;

  // Load sequencing and datapath
  sgl_ld_e                ld_state;
  sgl_ld_e                next_ld_state;
  logic                   shift_en;
  logic [WIDTH-1:0]       shift_reg;
  logic [WIDTH-1:0]       next_shift_reg;
  logic [GAIN_W-1:0]      next_gain;

  // Sleep settle timer
  logic [SLEEP_CNT_W-1:0] sleep_cnt;
  logic [SLEEP_CNT_W-1:0] next_sleep_cnt;
  logic                   sleep_due;

  // Amplifier mode
  sgl_amp_s               next_amp;

  // Pin carrier as a plain vector
  assign pins_raw = i_pins;

  // Three flops per pin, then a filter waiting for stages two and three to agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_pin
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          sync1[gi] <= PIN_IDLE[gi];
          sync2[gi] <= PIN_IDLE[gi];
          sync3[gi] <= PIN_IDLE[gi];
        end else begin
          sync1[gi] <= pins_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end

      // Filtered level and its one-cycle delayed copy
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          filt[gi]   <= PIN_IDLE[gi];
          filt_d[gi] <= PIN_IDLE[gi];
        end else begin
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
          filt_d[gi] <= filt[gi];
        end
      end
    end
  endgenerate

  // Edge strobes from the filtered pins
  assign sclk_rise  = filt.sclk & ~filt_d.sclk;
  assign load_rise  = filt.load_enable_n & ~filt_d.load_enable_n;
  assign load_fall  = ~filt.load_enable_n & filt_d.load_enable_n;
  assign sleep_edge = filt.amp_sleep_n ^ filt_d.amp_sleep_n;

  // Load phase register, holding after reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ld_state <= SGL_LD_HOLD;
    end else begin
      ld_state <= next_ld_state;
    end
  end

  // Falling load enable opens shifting, rising load enable closes it
  always_comb begin
    next_ld_state = ld_state;
    case (ld_state)
      SGL_LD_HOLD: begin
        if (load_fall) begin
          next_ld_state = SGL_LD_SHIFT;
        end
      end
      SGL_LD_SHIFT: begin
        if (load_rise) begin
          next_ld_state = SGL_LD_HOLD;
        end
      end
      default: begin
        next_ld_state = SGL_LD_HOLD;
      end
    endcase
  end

  // Shift clock gate, shut in the very cycle that load enable rises
  assign shift_en = (next_ld_state == SGL_LD_SHIFT);

  // Next shift value, MSB first
  always_comb begin
    next_shift_reg = shift_reg;
    if (sclk_rise && shift_en) begin
      next_shift_reg = {shift_reg[WIDTH-2:0], filt.serial_gain_in};
    end
  end

  // Shift register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= next_shift_reg;
    end
  end

  // One latch bit per attenuator stage, closed while load enable is low
  genvar si;
  generate
    for (si = 0; si < WIDTH; si = si + 1) begin : g_stage
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          o_atten_sel[si] <= 1'b0;
        end else if (load_rise) begin
          o_atten_sel[si] <= shift_reg[si];
        end
      end
    end
  endgenerate

  // Gain in milli V/V, unsigned code times step plus offset
  assign next_gain = GAIN_W'(GAIN_OFFSET_MILLI + GAIN_STEP_MILLI * shift_reg);

  // Gain register, moves together with the latch
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_gain_milli <= GAIN_W'(GAIN_OFFSET_MILLI);
    end else if (load_rise) begin
      o_gain_milli <= next_gain;
    end
  end

  // Valid after the first completed load
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_code_valid <= 1'b0;
    end else if (load_rise) begin
      o_code_valid <= 1'b1;
    end
  end

  // Settle count restarts on each filtered sleep change, stops at the limit
  always_comb begin
    next_sleep_cnt = sleep_cnt;
    if (sleep_edge) begin
      next_sleep_cnt = '0;
    end else if (sleep_cnt < SLEEP_CNT_W'(SLEEP_CYC)) begin
      next_sleep_cnt = sleep_cnt + 1'b1;
    end
  end

  // Settle counter
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sleep_cnt <= '0;
    end else begin
      sleep_cnt <= next_sleep_cnt;
    end
  end

  // Mode switch falls due one count before the limit
  assign sleep_due = (sleep_cnt == SLEEP_CNT_W'(SLEEP_CYC - 1));

  // Mode chosen by the settled sleep level, code latch untouched
  always_comb begin
    next_amp = o_amp;
    if (sleep_due) begin
      if (filt.amp_sleep_n) begin
        next_amp = AMP_FWD;
      end else begin
        next_amp = AMP_REV;
      end
    end
  end

  // Amplifier mode register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_amp <= AMP_FWD;
    end else begin
      o_amp <= next_amp;
    end
  end

endmodule : sgl_loader
`default_nettype wire

// file: sgl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sgl_monitor import sgl_pkg::*; (
  input wire logic              i_ref_clk,
  input wire logic              i_rst,
  input wire sgl_pins_s         i_pins,
  input wire logic [CODE_W-1:0] o_atten_sel,
  input wire logic [GAIN_W-1:0] o_gain_milli,
  input wire logic              o_code_valid,
  input wire sgl_amp_s          o_amp
);
  // Pin shorthands and shared clocking
  wire logic ld = i_pins.load_enable_n;
  wire logic sl = i_pins.amp_sleep_n;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_law;
    o_gain_milli == GAIN_OFFSET_MILLI + GAIN_STEP_MILLI * o_atten_sel;
  endproperty
  a_law: assert property (p_law) else $error("law");
  property p_hold; !ld [*8] |-> $stable(o_atten_sel); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_cause; $changed(o_atten_sel) |-> $past(ld, 4); endproperty
  a_cause: assert property (p_cause) else $error("cause");
  property p_load; $rose(ld) |-> ##[3:8] o_code_valid; endproperty
  a_load: assert property (p_load) else $error("load");
  property p_keep; o_code_valid |=> o_code_valid; endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_rev; $fell(sl) |-> ##[10:16] o_amp == AMP_REV; endproperty
  a_rev: assert property (p_rev) else $error("rev");
  property p_fwd; $rose(sl) |-> ##[10:16] o_amp == AMP_FWD; endproperty
  a_fwd: assert property (p_fwd) else $error("fwd");
  property p_mode; $changed(o_amp) |-> o_amp == (sl ? AMP_FWD : AMP_REV); endproperty
  a_mode: assert property (p_mode) else $error("mode");
endmodule : sgl_monitor
bind sgl_loader sgl_monitor sgl_monitor_inst (.i_ref_clk, .i_rst, .i_pins, .o_atten_sel,
  .o_gain_milli, .o_code_valid, .o_amp);
`default_nettype wire

// file: sgl_host.sv
`timescale 1ns/1ps
`default_nettype none
module sgl_host import sgl_pkg::*; (
  input wire logic i_clk,
  output var sgl_pins_s o_pins
);
  // Idle: clock low, load and sleep high
  initial o_pins = 4'h7;
  // Frame of n bits MSB first; f low keeps load high
  task automatic send(input logic [7:0] c, input int n, input logic f);
    o_pins.load_enable_n <= !f;
    for (int i = 7; i > 7 - n; i--) begin
      o_pins.serial_gain_in <= c[i];
      repeat (4) @(posedge i_clk);
      o_pins.sclk <= 1'h1;
      repeat (4) @(posedge i_clk);
      o_pins.sclk <= 1'h0;
      repeat (4) @(posedge i_clk);
    end
    o_pins.load_enable_n <= 1'h1;
    o_pins.serial_gain_in <= !c[8 - n];
    repeat (12) @(posedge i_clk);
  endtask : send
endmodule : sgl_host
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import sgl_pkg::*; ;
  logic clk = 0, rst = 1, vld;
  int fail_count, n_checks, cyc;
  logic [31:0] seed = 32'h1530;
  logic [7:0] sh, sel;
  logic [14:0] gain;
  sgl_pins_s pins;
  sgl_amp_s amp;
  // Clock and instances
  always #2.5 clk = ~clk;
  sgl_host sgl_host_inst (.i_clk(clk), .o_pins(pins));
  sgl_loader sgl_loader_inst (.i_ref_clk(clk), .i_rst(rst), .i_pins(pins),
    .o_atten_sel(sel), .o_gain_milli(gain), .o_code_valid(vld), .o_amp(amp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Send, follow the shift register, check the latch
  task automatic load(input logic [7:0] c, input int n, input logic f);
    sgl_host_inst.send(c, n, f);
    for (int i = 0; i < (f ? n : 0); i++) sh = {sh[6:0], c[7 - i]};
    chk("sel", 15'(sh), 15'(sel));
    chk("gain", 15'(GAIN_OFFSET_MILLI + GAIN_STEP_MILLI * sh), gain);
  endtask : load
  task automatic summarize;
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Corner and random codes, unframed clocks, sleep
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    chk("vld", 15'h0, 15'(vld));
    load(8'h00, 8, 1);
    chk("vld", 15'h1, 15'(vld));
    load(8'hff, 8, 1);
    load(8'h80, 8, 1);
    repeat (12) begin
      seed = lfsr(seed);
      load(seed[7:0], 8, 1);
    end
    load(seed[15:8], 8, 0);
    load(8'ha5, 4, 1);
    sgl_host_inst.o_pins.amp_sleep_n <= 1'h0;
    repeat (20) @(posedge clk);
    chk("amp", 15'(AMP_REV), 15'(amp));
    chk("sel", 15'(sh), 15'(sel));
    load(seed[23:16], 8, 1);
    sgl_host_inst.o_pins.amp_sleep_n <= 1'h1;
    repeat (20) @(posedge clk);
    chk("amp", 15'(AMP_FWD), 15'(amp));
    summarize();
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      summarize();
    end
  end
endmodule : tb_top
`default_nettype wire
